// [rtl/port_io_flags.sv]
`timescale 1ns/1ns
module port_io_flags
  import port_io_pkg::*;
(
  // operands
  input  wire logic [7:0] data_in,
  input  wire logic [7:0] cnt_next,
  input  wire logic [7:0] f_old,
  // results
  output logic      [7:0] f_in,
  output logic      [7:0] f_blk
);

  always_comb begin
    f_in          = f_old;
    f_in[FLAG_S]  = data_in[7];
    f_in[FLAG_Z]  = (data_in == 8'h00);
    f_in[FLAG_H]  = 1'b0;
    f_in[FLAG_PV] = ~^data_in;
    f_in[FLAG_N]  = 1'b0;
    // sign, half and parity are left as they were: undefined to software
    f_blk         = f_old;
    f_blk[FLAG_Z] = (cnt_next == 8'h00);
    f_blk[FLAG_N] = 1'b1;
  end

endmodule : port_io_flags

// [rtl/port_io_instruction_unit.sv]
`timescale 1ns/1ns
module port_io_instruction_unit
  import port_io_pkg::*;
#(
  parameter int TSTATE_DIV = 1
) (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       arst_n,
  // instruction request
  input  wire logic       cmd_valid,
  input  wire io_cmd_t    cmd,
  output logic            cmd_ready,
  output logic            cmd_done,
  output logic            busy,
  // register preload while idle
  input  wire reg_load_t  reg_load,
  // interrupt between iterations
  input  wire logic       int_req,
  output logic            int_ack,
  // port bus
  output logic [15:0]     io_addr,
  output logic [7:0]      io_wdata,
  output logic            io_rd,
  output logic            io_wr,
  input  wire logic [7:0] io_rdata,
  output logic            refresh,
  output logic [2:0]      m_cycle,
  // memory write stream
  output logic            mem_valid,
  input  wire logic       mem_ready,
  output mem_wr_t         mem_wr,
  // architectural state, index 6 holds the flags
  output logic [7:0][7:0] regs,
  output logic [15:0]     program_counter
);

  if (TSTATE_DIV < 1 || TSTATE_DIV > 256) begin : g_bad_div
    $error("TSTATE_DIV must lie in 1..256");
  end

  localparam logic [7:0] DIV_LAST = 8'(TSTATE_DIV - 1);

  // ==========================================================
  // state
  typedef struct packed {
    logic            rdy;
    logic            busy;
    logic            done;
    logic            int_ack;
    logic            io_rd;
    logic            io_wr;
    logic            refresh;
    io_op_t          op;
    logic [2:0]      sel;
    logic [7:0]      port;
    logic [2:0]      mc;
    logic [2:0]      tc;
    logic [4:0]      tot;
    logic [7:0]      div;
    logic [7:0]      latch;
    logic [15:0]     addr;
    logic [7:0]      wdata;
    logic [7:0][7:0] regs;
    logic [15:0]     pc;
  } unit_t;

  localparam unit_t UNIT_RESET = '{rdy: 1'b1, op: OP_IN_C, default: '0};

  unit_t       s_q;
  unit_t       s_d;
  logic        tick;
  logic        last_t;
  logic        push;
  logic        stall;
  logic        adv;
  logic        fin;
  logic        io_end;
  logic        mem_end;
  logic        m5_end;
  logic        buf_ready;
  logic [15:0] hl;
  logic [15:0] hl_next;
  logic [7:0]  b_next;
  logic [7:0]  f_in;
  logic [7:0]  f_blk;
  mem_wr_t     push_data;

  function automatic logic is_blk(input io_op_t op);
    return op inside {OP_BLK_INC, OP_BLK_DEC, OP_BLK_INC_REP, OP_BLK_DEC_REP};
  endfunction : is_blk

  function automatic logic is_rep(input io_op_t op);
    return op inside {OP_BLK_INC_REP, OP_BLK_DEC_REP};
  endfunction : is_rep

  function automatic logic is_inc(input io_op_t op);
    return op inside {OP_BLK_INC, OP_BLK_INC_REP};
  endfunction : is_inc

  // T-states per machine cycle
  function automatic logic [2:0] mlen(input io_op_t op, input logic [2:0] mc);
    logic [2:0] len;
    len = T_STD;
    case (mc)
      MC_OPERAND: begin
        if (is_blk(op)) len = T_BLK_M2;
        else if (op == OP_OUT_N) len = T_SHORT;
      end
      MC_IO: begin
        if (is_blk(op)) len = T_SHORT;
      end
      MC_RFSH: len = T_BLK_M5;
      default: len = T_STD;
    endcase
    return len;
  endfunction : mlen

  assign hl        = {s_q.regs[SEL_H], s_q.regs[SEL_L]};
  assign b_next    = s_q.regs[SEL_B] - CNT_STEP;
  assign hl_next   = is_inc(s_q.op) ? hl + PTR_STEP : hl - PTR_STEP;
  assign push_data = '{addr: hl, data: s_q.latch};

  port_io_flags u_flags (
    .data_in  (io_rdata),
    .cnt_next (b_next),
    .f_old    (s_q.regs[SEL_FLAGS]),
    .f_in     (f_in),
    .f_blk    (f_blk)
  );

  // the buffer lets a slow memory stall the block without losing a byte
  port_io_skid #(
    .DEPTH (2)
  ) u_skid (
    .clk_sys   (clk_sys),
    .arst_n    (arst_n),
    .in_valid  (push),
    .in_data   (push_data),
    .in_ready  (buf_ready),
    .out_valid (mem_valid),
    .out_ready (mem_ready),
    .out_data  (mem_wr)
  );

  // ==========================================================
  // sequencer
  always_comb begin
    s_d       = s_q;
    s_d.done    = 1'b0;
    s_d.int_ack = 1'b0;
    s_d.refresh = 1'b0;
    fin       = 1'b0;
    io_end    = 1'b0;
    mem_end   = 1'b0;
    m5_end    = 1'b0;
    tick      = (s_q.div == DIV_LAST);
    s_d.div   = tick ? 8'h00 : s_q.div + 8'h01;
    last_t    = (s_q.tc == mlen(s_q.op, s_q.mc) - 3'h1);
    push      = s_q.busy && tick && is_blk(s_q.op) && s_q.mc == MC_MEM && last_t;
    stall     = push && !buf_ready;
    adv       = s_q.busy && tick && !stall;
    if (reg_load.we && !s_q.busy) begin
      if (reg_load.sel == LD_PC) s_d.pc = reg_load.value;
      else s_d.regs[reg_load.sel[2:0]] = reg_load.value[7:0];
    end
    if (cmd_valid && s_q.rdy) begin
      s_d.rdy  = 1'b0;
      s_d.busy = 1'b1;
      s_d.op   = cmd.op;
      s_d.sel  = cmd.sel;
      s_d.port = cmd.port;
      s_d.mc   = MC_FETCH;
      s_d.tc   = 3'h0;
      s_d.tot  = 5'h00;
    end else if (adv) begin
      s_d.tot = s_q.tot + 5'h01;
      if (!last_t) begin
        s_d.tc = s_q.tc + 3'h1;
        if (s_q.mc == MC_RFSH && (s_q.tc == REF_T0 || s_q.tc == REF_T1)) begin
          s_d.refresh = 1'b1;
        end
      end else begin
        s_d.tc = 3'h0;
        s_d.mc = s_q.mc + 3'h1;
        case (s_q.mc)
          MC_OPERAND: begin
            if (s_q.op == OP_OUT_N) begin
              s_d.addr  = {s_q.regs[SEL_A], s_q.port};
              s_d.wdata = s_q.regs[SEL_A];
            end else begin
              s_d.addr  = {s_q.regs[SEL_B], s_q.regs[SEL_C]};
              s_d.wdata = s_q.regs[s_q.sel];
            end
            s_d.io_rd = (s_q.op == OP_IN_C) || is_blk(s_q.op);
            s_d.io_wr = (s_q.op == OP_OUT_N) || (s_q.op == OP_OUT_C);
          end
          MC_IO: begin
            io_end    = 1'b1;
            s_d.io_rd = 1'b0;
            s_d.io_wr = 1'b0;
            if (s_q.op == OP_IN_C) begin
              // code 110 has no general register, only flags change
              if (s_q.sel != SEL_FLAGS) s_d.regs[s_q.sel] = io_rdata;
              s_d.regs[SEL_FLAGS] = f_in;
              fin = 1'b1;
            end else if (is_blk(s_q.op)) begin
              s_d.latch = io_rdata;
              s_d.addr  = hl;
            end else begin
              fin = 1'b1;
            end
          end
          MC_MEM: begin
            mem_end             = 1'b1;
            s_d.regs[SEL_B]     = b_next;
            s_d.regs[SEL_H]     = hl_next[15:8];
            s_d.regs[SEL_L]     = hl_next[7:0];
            s_d.regs[SEL_FLAGS] = f_blk;
            if (is_rep(s_q.op) && b_next != 8'h00) begin
              s_d.pc = s_q.pc - PC_BACK;
            end else begin
              fin = 1'b1;
            end
          end
          MC_RFSH: begin
            m5_end = 1'b1;
            if (int_req) begin
              s_d.int_ack = 1'b1;
              fin         = 1'b1;
            end else begin
              s_d.mc  = MC_FETCH;
              s_d.tot = 5'h00;
            end
          end
          default: begin
          end
        endcase
      end
    end
    if (fin) begin
      s_d.busy = 1'b0;
      s_d.rdy  = 1'b1;
      s_d.done = 1'b1;
      // idle always shows the fetch cycle, never a code past the last one
      s_d.mc   = MC_FETCH;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= UNIT_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign cmd_ready       = s_q.rdy;
  assign cmd_done        = s_q.done;
  assign busy            = s_q.busy;
  assign int_ack         = s_q.int_ack;
  assign io_addr         = s_q.addr;
  assign io_wdata        = s_q.wdata;
  assign io_rd           = s_q.io_rd;
  assign io_wr           = s_q.io_wr;
  assign refresh         = s_q.refresh;
  assign m_cycle         = s_q.mc;
  assign regs            = s_q.regs;
  assign program_counter = s_q.pc;

  // ==========================================================
  // checks
  logic [2:0] rf_cnt_q;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rf_cnt_q <= 3'h0;
    end else if (mem_end) begin
      rf_cnt_q <= 3'h0;
    end else if (s_q.refresh) begin
      rf_cnt_q <= rf_cnt_q + 3'h1;
    end
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);

  property p_port_addr;
    s_q.io_rd && s_q.op == OP_IN_C |-> s_q.addr == {s_q.regs[SEL_B], s_q.regs[SEL_C]};
  endproperty
  a_port_addr: assert property (p_port_addr) else $error("port address wrong");

  property p_in_dest;
    io_end && s_q.op == OP_IN_C && s_q.sel != SEL_FLAGS
      |=> s_q.regs[s_q.sel] == $past(io_rdata);
  endproperty
  a_in_dest: assert property (p_in_dest) else $error("input byte not stored");

  property p_in_flags;
    io_end && s_q.op == OP_IN_C |=> s_q.regs[SEL_FLAGS][FLAG_S] == $past(io_rdata[7])
      && s_q.regs[SEL_FLAGS][FLAG_Z] == ($past(io_rdata) == 8'h00)
      && s_q.regs[SEL_FLAGS][FLAG_PV] == ~^$past(io_rdata)
      && !s_q.regs[SEL_FLAGS][FLAG_H] && !s_q.regs[SEL_FLAGS][FLAG_N]
      && $stable(s_q.regs[SEL_FLAGS][FLAG_C]);
  endproperty
  a_in_flags: assert property (p_in_flags) else $error("input flags wrong");

  property p_reg_io_time;
    fin && s_q.op inside {OP_IN_C, OP_OUT_C} |-> s_q.tot == 5'(T_TOTAL_REG_IO - 1);
  endproperty
  a_reg_io_time: assert property (p_reg_io_time) else $error("indirect io not 12");

  property p_inc_step;
    mem_end && s_q.op == OP_BLK_INC
      |=> hl == $past(hl) + PTR_STEP && s_q.regs[SEL_B] == $past(s_q.regs[SEL_B]) - CNT_STEP;
  endproperty
  a_inc_step: assert property (p_inc_step) else $error("increment step wrong");

  property p_dec_step;
    mem_end && s_q.op == OP_BLK_DEC
      |=> hl == $past(hl) - PTR_STEP && s_q.regs[SEL_B] == $past(s_q.regs[SEL_B]) - CNT_STEP;
  endproperty
  a_dec_step: assert property (p_dec_step) else $error("decrement step wrong");

  property p_blk_single;
    fin && s_q.op inside {OP_BLK_INC, OP_BLK_DEC} |-> s_q.tot == 5'(T_TOTAL_BLK - 1)
      ##1 s_q.regs[SEL_FLAGS][FLAG_N] && s_q.regs[SEL_FLAGS][FLAG_Z] == (s_q.regs[SEL_B] == 8'h00);
  endproperty
  a_blk_single: assert property (p_blk_single) else $error("single block wrong");

  property p_rep_inc;
    mem_end && s_q.op == OP_BLK_INC_REP
      |=> hl == $past(hl) + PTR_STEP && s_q.busy == (s_q.regs[SEL_B] != 8'h00);
  endproperty
  a_rep_inc: assert property (p_rep_inc) else $error("repeat increment wrong");

  property p_rep_dec;
    mem_end && s_q.op == OP_BLK_DEC_REP
      |=> hl == $past(hl) - PTR_STEP && s_q.busy == (s_q.regs[SEL_B] != 8'h00);
  endproperty
  a_rep_dec: assert property (p_rep_dec) else $error("repeat decrement wrong");

  property p_pc_back;
    mem_end && is_rep(s_q.op) && b_next != 8'h00 |=> s_q.pc == $past(s_q.pc) - PC_BACK;
  endproperty
  a_pc_back: assert property (p_pc_back) else $error("program counter not moved back");

  property p_between;
    m5_end |-> rf_cnt_q == 3'(REFRESH_PER_IT) ##1 (s_q.int_ack == $past(int_req))
      && (s_q.busy != $past(int_req));
  endproperty
  a_between: assert property (p_between) else $error("iteration boundary wrong");

  property p_wrap;
    mem_end && is_rep(s_q.op) && s_q.regs[SEL_B] == 8'h00 |=> s_q.regs[SEL_B] == 8'hff && s_q.busy;
  endproperty
  a_wrap: assert property (p_wrap) else $error("zero count did not wrap");

  property p_rep_time;
    (m5_end |-> s_q.tot == 5'(T_TOTAL_REP - 1))
      and (fin && is_rep(s_q.op) && mem_end |-> s_q.tot == 5'(T_TOTAL_BLK - 1));
  endproperty
  a_rep_time: assert property (p_rep_time) else $error("repeat timing wrong");

  property p_out_n;
    s_q.io_wr && s_q.op == OP_OUT_N
      |-> s_q.addr == {s_q.regs[SEL_A], s_q.port} && s_q.wdata == s_q.regs[SEL_A];
  endproperty
  a_out_n: assert property (p_out_n) else $error("direct output wrong");

  property p_out_n_time;
    fin && s_q.op == OP_OUT_N |-> s_q.tot == 5'(T_TOTAL_OUTN - 1)
      && s_q.regs[SEL_FLAGS] == s_d.regs[SEL_FLAGS];
  endproperty
  a_out_n_time: assert property (p_out_n_time) else $error("direct output timing wrong");

  property p_out_c;
    s_q.io_wr && s_q.op == OP_OUT_C |-> s_q.wdata == s_q.regs[s_q.sel];
  endproperty
  a_out_c: assert property (p_out_c) else $error("indirect output data wrong");

  property p_rep_end_flags;
    mem_end && is_rep(s_q.op) && b_next == 8'h00 |=> s_q.regs[SEL_FLAGS][FLAG_Z]
      && s_q.regs[SEL_FLAGS][FLAG_N] && $stable(s_q.regs[SEL_FLAGS][FLAG_C]) && s_q.done;
  endproperty
  a_rep_end_flags: assert property (p_rep_end_flags) else $error("repeat end flags wrong");

endmodule : port_io_instruction_unit

// [rtl/port_io_pkg.sv]
package port_io_pkg;

  // ==========================================================
  // operations and register encoding
  typedef enum logic [2:0] {
    OP_IN_C        = 3'h0,
    OP_BLK_INC     = 3'h1,
    OP_BLK_DEC     = 3'h2,
    OP_BLK_INC_REP = 3'h3,
    OP_BLK_DEC_REP = 3'h4,
    OP_OUT_N       = 3'h5,
    OP_OUT_C       = 3'h6
  } io_op_t;

  localparam logic [2:0] SEL_B     = 3'h0;
  localparam logic [2:0] SEL_C     = 3'h1;
  localparam logic [2:0] SEL_H     = 3'h4;
  localparam logic [2:0] SEL_L     = 3'h5;
  localparam logic [2:0] SEL_FLAGS = 3'h6;
  localparam logic [2:0] SEL_A     = 3'h7;
  localparam logic [3:0] LD_PC     = 4'h8;

  localparam int FLAG_S  = 7;
  localparam int FLAG_Z  = 6;
  localparam int FLAG_H  = 4;
  localparam int FLAG_PV = 2;
  localparam int FLAG_N  = 1;
  localparam int FLAG_C  = 0;

  // ==========================================================
  // machine cycles and T-state lengths
  localparam logic [2:0] MC_FETCH   = 3'h0;
  localparam logic [2:0] MC_OPERAND = 3'h1;
  localparam logic [2:0] MC_IO      = 3'h2;
  localparam logic [2:0] MC_MEM     = 3'h3;
  localparam logic [2:0] MC_RFSH    = 3'h4;

  localparam logic [2:0] T_STD    = 3'h4;
  localparam logic [2:0] T_SHORT  = 3'h3;
  localparam logic [2:0] T_BLK_M2 = 3'h5;
  localparam logic [2:0] T_BLK_M5 = 3'h5;
  localparam logic [2:0] REF_T0   = 3'h0;
  localparam logic [2:0] REF_T1   = 3'h2;

  localparam int T_TOTAL_REG_IO = 12;
  localparam int T_TOTAL_BLK    = 16;
  localparam int T_TOTAL_REP    = 21;
  localparam int T_TOTAL_OUTN   = 11;
  localparam int REFRESH_PER_IT = 2;

  localparam logic [15:0] PC_BACK  = 16'h0002;
  localparam logic [15:0] PTR_STEP = 16'h0001;
  localparam logic [7:0]  CNT_STEP = 8'h01;

  // ==========================================================
  // carriers
  typedef struct packed {
    io_op_t     op;
    logic [2:0] sel;
    logic [7:0] port;
  } io_cmd_t;

  typedef struct packed {
    logic        we;
    logic [3:0]  sel;
    logic [15:0] value;
  } reg_load_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  data;
  } mem_wr_t;

endpackage : port_io_pkg

// [rtl/port_io_skid.sv]
`timescale 1ns/1ns
module port_io_skid
  import port_io_pkg::*;
#(
  parameter int DEPTH = 2
) (
  // clock and reset
  input  wire logic    clk_sys,
  input  wire logic    arst_n,
  // filling side
  input  wire logic    in_valid,
  input  wire mem_wr_t in_data,
  output logic         in_ready,
  // draining side
  output logic         out_valid,
  input  wire logic    out_ready,
  output mem_wr_t      out_data
);

  if (DEPTH != 2) begin : g_bad_depth
    $error("port_io_skid serves exactly two entries");
  end

  typedef struct packed {
    logic    v0;
    logic    v1;
    mem_wr_t e0;
    mem_wr_t e1;
  } skid_t;

  skid_t s_q;
  skid_t s_d;
  logic  in_fire;
  logic  out_fire;

  assign in_ready  = !s_q.v1;
  assign out_valid = s_q.v0;
  assign out_data  = s_q.e0;
  assign in_fire   = in_valid && !s_q.v1;
  assign out_fire  = s_q.v0 && out_ready;

  // head always sits in e0 so the output is a plain flop
  always_comb begin
    s_d = s_q;
    if (out_fire) begin
      s_d.e0 = s_q.e1;
      s_d.v0 = s_q.v1;
      s_d.v1 = 1'b0;
    end
    if (in_fire) begin
      if (!s_d.v0) begin
        s_d.e0 = in_data;
        s_d.v0 = 1'b1;
      end else begin
        s_d.e1 = in_data;
        s_d.v1 = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

endmodule : port_io_skid

// [testbench/port_io_instruction_unit_tb.sv]
`timescale 1ns/1ns
module port_io_instruction_unit_tb;
  import port_io_pkg::*;
  typedef struct {io_op_t op; logic [2:0] sel; logic [7:0] base; int t;} row_t;
  localparam logic [7:0] INIT [8] = '{8'h10, 8'h07, 8'h5a, 8'h3c, 8'h12, 8'h34, 8'h13, 8'h23};
  logic            clk_sys = 1'b0;
  logic            arst_n = 1'b0;
  logic            cmd_valid = 1'b0;
  io_cmd_t         cmd = '0;
  reg_load_t       reg_load = '0;
  logic            int_req = 1'b0;
  logic            stall = 1'b0;
  logic [7:0]      rd_base = 8'h00;
  logic            cmd_ready, cmd_done, busy, int_ack, io_rd, io_wr, refresh;
  logic            mem_valid, mem_ready;
  logic [15:0]     io_addr, program_counter, rd_addr, wr_addr, mem_n;
  logic [7:0]      io_wdata, io_rdata, rd_n, wr_data;
  logic [2:0]      m_cycle;
  mem_wr_t         mem_wr, mem_last;
  logic [7:0][7:0] regs;
  logic [15:0]     ptr_now;
  int              miscompares = 0;
  int              num_checks = 0;
  int              cyc, nref, nack;
  row_t            rows [12] = '{
    '{OP_IN_C, 3'h0, 8'h80, 12}, '{OP_IN_C, 3'h1, 8'h0f, 12}, '{OP_IN_C, 3'h2, 8'h00, 12},
    '{OP_IN_C, 3'h3, 8'hff, 12}, '{OP_IN_C, 3'h4, 8'h55, 12}, '{OP_IN_C, 3'h5, 8'h03, 12},
    '{OP_IN_C, 3'h7, 8'h7b, 12}, '{OP_OUT_C, 3'h3, 8'h00, 12}, '{OP_OUT_C, 3'h7, 8'h00, 12},
    '{OP_OUT_N, 3'h0, 8'h00, 11}, '{OP_BLK_INC, 3'h0, 8'h61, 16}, '{OP_BLK_DEC, 3'h0, 8'h62, 16}};

  always #4 clk_sys = ~clk_sys;

  // pointer pair: high byte sits in slot 4, low byte in slot 5
  assign ptr_now = {regs[4], regs[5]};

  port_io_instruction_unit DUT (.clk_sys(clk_sys), .arst_n(arst_n), .cmd_valid(cmd_valid),
    .cmd(cmd), .cmd_ready(cmd_ready), .cmd_done(cmd_done), .busy(busy), .reg_load(reg_load),
    .int_req(int_req), .int_ack(int_ack), .io_addr(io_addr), .io_wdata(io_wdata), .io_rd(io_rd),
    .io_wr(io_wr), .io_rdata(io_rdata), .refresh(refresh), .m_cycle(m_cycle),
    .mem_valid(mem_valid), .mem_ready(mem_ready), .mem_wr(mem_wr), .regs(regs),
    .program_counter(program_counter));

  port_io_peripheral PEER (.clk_sys(clk_sys), .io_addr(io_addr), .io_rd(io_rd), .io_wr(io_wr),
    .io_wdata(io_wdata), .io_rdata(io_rdata), .mem_valid(mem_valid), .mem_wr(mem_wr),
    .mem_ready(mem_ready), .stall(stall), .rd_base(rd_base), .rd_n(rd_n), .rd_addr(rd_addr),
    .wr_addr(wr_addr), .wr_data(wr_data), .mem_n(mem_n), .mem_last(mem_last));

  // ==========================================================
  // helpers
  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict

  // preload only while idle; the unit ignores loads while busy
  task automatic setup(input logic [7:0] b, input logic [15:0] hl);
    for (int i = 0; i < 8; i++) begin
      reg_load = {1'b1, 4'(i), 8'h00, (i == 0) ? b : (i == 4) ? hl[15:8] :
                  (i == 5) ? hl[7:0] : INIT[i]};
      @(negedge clk_sys);
    end
    reg_load = '0;
  endtask : setup

  task automatic run(input io_op_t op, input logic [2:0] sel);
    cyc = 0;
    nref = 0;
    nack = 0;
    cmd = '{op: op, sel: sel, port: 8'h01};
    cmd_valid = 1'b1;
    do begin
      @(negedge clk_sys);
      cmd_valid = 1'b0;
      cyc++;
      nref += int'(refresh === 1'b1);
      nack += int'(int_ack === 1'b1);
    end while (cmd_done !== 1'b1 && cyc < 8000);
    if (cyc >= 8000) chk("done", 24'h1, 24'h0);
    // let the buffer drain before memory is inspected
    repeat (3) @(negedge clk_sys);
  endtask : run

  // ==========================================================
  // sequence
  initial begin
    logic [7:0]  d;
    logic [7:0]  n0;
    logic [15:0] m0;
    repeat (10) @(negedge clk_sys);
    arst_n = 1'b1;
    chk("ready", 24'h1, 24'(cmd_ready));
    chk("busy", 24'h0, 24'(busy));
    chk("m_cycle", 24'h0, 24'(m_cycle));
    chk("pc", 24'h0, 24'(program_counter));
    chk("regs", 24'h0, regs[7:5]);
    $display("test reset done");
    foreach (rows[i]) begin
      setup(8'h10, 16'h1234);
      // offset the running read count so the port returns exactly the row's byte
      rd_base = rows[i].base - rd_n;
      d = rows[i].base;
      run(rows[i].op, rows[i].sel);
      chk("cycles", 24'(rows[i].t + 1), 24'(cyc));
      case (rows[i].op)
        OP_IN_C: begin
          chk("rd_addr", 24'h1007, 24'(rd_addr));
          chk("dest", 24'(d), 24'(regs[rows[i].sel]));
          chk("flags", 24'({d[7], d == 8'h00, 3'b000, ~^d, 2'b01}), 24'(regs[6] & 8'hd7));
        end
        OP_OUT_N: begin
          chk("wr_addr", 24'h2301, 24'(wr_addr));
          chk("wr_data", 24'h23, 24'(wr_data));
          chk("flags", 24'h13, 24'(regs[6]));
        end
        OP_OUT_C: begin
          chk("wr_addr", 24'h1007, 24'(wr_addr));
          chk("wr_data", 24'(INIT[rows[i].sel]), 24'(wr_data));
        end
        default: begin
          chk("mem", {16'h1234, d}, mem_last);
          chk("count", 24'h0f, 24'(regs[0]));
          chk("ptr", (rows[i].op == OP_BLK_INC) ? 24'h1235 : 24'h1233, 24'(ptr_now));
          chk("flags", 24'h03, 24'(regs[6] & 8'h43));
        end
      endcase
      $display("test row %0d done", i);
    end
    setup(8'h02, 16'h2000);
    @(negedge clk_sys);
    reg_load = {1'b1, LD_PC, 16'h0100};
    @(negedge clk_sys);
    reg_load = '0;
    int_req = 1'b1;
    run(OP_BLK_INC_REP, 3'h0);
    int_req = 1'b0;
    chk("cycles", 24'd22, 24'(cyc));
    chk("int_ack", 24'h1, 24'(nack));
    chk("refresh", 24'h2, 24'(nref));
    chk("pc", 24'h00fe, 24'(program_counter));
    chk("count", 24'h01, 24'(regs[0]));
    chk("m_cycle", 24'h0, 24'(m_cycle));
    $display("test interrupt done");
    setup(8'h03, 16'h1000);
    rd_base = 8'h51;
    n0 = rd_n;
    m0 = mem_n;
    run(OP_BLK_INC_REP, 3'h0);
    chk("cycles", 24'd59, 24'(cyc));
    chk("refresh", 24'h4, 24'(nref));
    chk("count", 24'h0, 24'(regs[0]));
    chk("ptr", 24'h1003, 24'(ptr_now));
    chk("flags", 24'h43, 24'(regs[6] & 8'h43));
    chk("mem_n", 24'h3, 24'(mem_n - m0));
    chk("mem", {16'h1002, 8'(8'h53 + n0)}, mem_last);
    $display("test repeat done");
    setup(8'h00, 16'h1000);
    n0 = rd_n;
    m0 = mem_n;
    run(OP_BLK_DEC_REP, 3'h0);
    chk("cycles", 24'd5372, 24'(cyc));
    chk("mem_n", 24'h100, 24'(mem_n - m0));
    chk("ptr", 24'h0f00, 24'(ptr_now));
    chk("mem", {16'h0f01, 8'(8'h50 + n0)}, mem_last);
    $display("test wrap done");
    setup(8'h04, 16'h3000);
    n0 = rd_n;
    m0 = mem_n;
    stall = 1'b1;
    fork
      run(OP_BLK_INC_REP, 3'h0);
      begin
        repeat (300) @(negedge clk_sys);
        stall = 1'b0;
      end
    join
    chk("mem_n", 24'h4, 24'(mem_n - m0));
    chk("mem", {16'h3003, 8'(8'h54 + n0)}, mem_last);
    chk("ptr", 24'h3004, 24'(ptr_now));
    $display("test stall done");
    give_verdict();
  end

  initial begin
    #(8 * 20000);
    miscompares++;
    give_verdict();
  end
endmodule : port_io_instruction_unit_tb

// [testbench/port_io_peripheral.sv]
`timescale 1ns/1ns
module port_io_peripheral
  import port_io_pkg::*;
(
  // clock
  input  wire logic        clk_sys,
  // port bus
  input  wire logic [15:0] io_addr,
  input  wire logic        io_rd,
  input  wire logic        io_wr,
  input  wire logic [7:0]  io_wdata,
  output logic      [7:0]  io_rdata,
  // memory sink
  input  wire logic        mem_valid,
  input  wire mem_wr_t     mem_wr,
  output logic             mem_ready,
  // bench controls and records
  input  wire logic        stall,
  input  wire logic [7:0]  rd_base,
  output logic      [7:0]  rd_n,
  output logic      [15:0] rd_addr,
  output logic      [15:0] wr_addr,
  output logic      [7:0]  wr_data,
  output logic      [15:0] mem_n,
  output mem_wr_t          mem_last
);
  logic rd_q = 1'b0;
  initial begin
    rd_n = '0;
    mem_n = '0;
  end
  // one byte per read; released bus shows the inverse, not a stale copy
  assign io_rdata  = io_rd ? rd_base + rd_n : ~(rd_base + rd_n);
  assign mem_ready = !stall;
  always @(posedge clk_sys) begin
    rd_q <= io_rd;
    if (io_rd) rd_addr <= io_addr;
    if (rd_q && !io_rd) rd_n <= rd_n + 8'h01;
    if (io_wr) begin
      wr_addr <= io_addr;
      wr_data <= io_wdata;
    end
    if (mem_valid && mem_ready) begin
      mem_n    <= mem_n + 16'h0001;
      mem_last <= mem_wr;
    end
  end
endmodule : port_io_peripheral
